// *** design/supply_fault_detector.sv ***
// Overview of operation
// (R01) ten channels, each with its own type, thresholds, range, hysteresis, filter
// (R02) under-voltage type faults only when input falls below its threshold
// (R03) over-voltage type faults only when input rises above its threshold
// (R04) out-of-window type faults on under-voltage OR over-voltage condition
// (R05) over-voltage fault releases only below threshold minus hysteresis
// (R06) under-voltage fault releases only above threshold plus hysteresis
// (R07) glitch filter selectable among eight periods from 0 to 100 us
// (R08) per-input ranges span 0.573 V to 14.4 V; configurator picks one
// (R09) configurator programs thresholds as in-range codes, clamping outside values
// (R10) configurator must not set under threshold above over threshold in window
// (R11) dual-function inputs may be digital; rail and high-voltage inputs analog only
// (R12) dual-function input in analog mode has exactly one range
// (R13) filtered fault changes after raw level held for selected period
// (R14) disabled fault type keeps the fault output low
module supply_fault_detector
    import supply_fault_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           nrst,
    input  wire logic [NUM_CH-1:0][THR_W-1:0]   rail_code,
    input  wire fault_type_t [NUM_CH-1:0]       fault_type,
    input  wire logic [NUM_CH-1:0][THR_W-1:0]   uv_thr,
    input  wire logic [NUM_CH-1:0][THR_W-1:0]   ov_thr,
    input  wire logic [NUM_CH-1:0][THR_W-1:0]   hyst,
    input  wire logic [NUM_CH-1:0][2:0]         filt_sel,
    input  wire logic [NUM_CH-1:0][1:0]         range_sel,
    input  wire logic [NUM_DUAL-1:0]            digital_mode,
    output logic      [NUM_CH-1:0]              fault,
    output logic      [NUM_CH-1:0][1:0]         range_eff
);
    typedef struct packed {
        logic [NUM_CH-1:0][THR_W-1:0] meta;
        logic [NUM_CH-1:0][THR_W-1:0] sync;
        logic [NUM_CH-1:0][1:0]       rng;
    } top_state_t;

    top_state_t           st_r;
    top_state_t           st_nxt;
    fault_type_t [NUM_CH-1:0] eff_type;

    // the converter codes come from the analog side, so two stages first
    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = rail_code;
        st_nxt.sync = st_r.meta;
        for (int i = 0; i < NUM_CH; i++) begin
            // a range past the input's last one clamps to that last one
            if (range_sel[i] > range_max(i)) begin
                st_nxt.rng[i] = range_max(i);  // see (R08)
            end else begin
                st_nxt.rng[i] = range_sel[i];  // see (R12)
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r.meta <= '{default: RST_CODE};
            st_r.sync <= '{default: RST_CODE};
            st_r.rng  <= '{default: RST_RNG};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign range_eff = st_r.rng;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch  // see (R01)
            if (g < NUM_DUAL) begin : gen_dual
                // digital use disconnects the analog detector from the pin
                assign eff_type[g] = digital_mode[g] ? FT_OFF : fault_type[g];  // see (R11)
            end else begin : gen_analog
                assign eff_type[g] = fault_type[g];  // see (R11)
            end

            fault_channel u_chan (
                .clk      (clk),
                .nrst     (nrst),
                .code     (st_r.sync[g]),
                .ftype    (eff_type[g]),
                .uv_thr   (uv_thr[g]),
                .ov_thr   (ov_thr[g]),
                .hyst     (hyst[g]),
                .filt_sel (filt_sel[g]),
                .fault    (fault[g])
            );
        end
    endgenerate

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_chk
            range_legal_a: assert property ( // see (R08)
                range_eff[g] <= range_max(g))
                else $error("effective range outside input's set");

            range_follow_a: assert property ( // see (R08)
                (range_sel[g] <= range_max(g)) |=> (range_eff[g] == $past(range_sel[g])))
                else $error("legal range not taken");

            off_quiet_a: assert property ( // see (R14)
                (fault_type[g] == FT_OFF) [*2] |-> !fault[g])
                else $error("disabled channel shows fault");

            // end to end: two sync stages, detector, filter; fault seen four edges on
            // applied type, so a dual input in digital use is left out
            uv_path_a: assert property ( // see (R02)
                (eff_type[g] == FT_UV) && (filt_sel[g] == 3'h0) && !fault[g]
                && (rail_code[g] < uv_thr[g])
                ##1 ((eff_type[g] == FT_UV) && (filt_sel[g] == 3'h0)
                && (rail_code[g] < uv_thr[g]) && $stable(uv_thr[g])) [*3]
                |=> fault[g])
                else $error("under-voltage fault not raised in time");

            ov_path_a: assert property ( // see (R03)
                (eff_type[g] == FT_OV) && (filt_sel[g] == 3'h0) && !fault[g]
                && (rail_code[g] > ov_thr[g])
                ##1 ((eff_type[g] == FT_OV) && (filt_sel[g] == 3'h0)
                && (rail_code[g] > ov_thr[g]) && $stable(ov_thr[g])) [*3]
                |=> fault[g])
                else $error("over-voltage fault not raised in time");

            // a rise under the longest filter needs the full count behind it
            filt_pulse_a: assert property ( // see (R07)
                (filt_sel[g] == 3'h7) && $stable(filt_sel[g]) && $rose(fault[g])
                |-> $past(gen_ch[g].u_chan.st_r.cnt) >= FILT_100_CYC)
                else $error("filter passed an edge before its period");
        end
        for (g = 0; g < NUM_DUAL; g++) begin : gen_dchk
            dual_digital_a: assert property ( // see (R11)
                digital_mode[g] [*2] |-> !fault[g])
                else $error("digital input drives analog fault");

            dual_range_a: assert property ( // see (R12)
                range_eff[g] == RNG_MAX_DUAL)
                else $error("dual input left its single range");
        end
    endgenerate

    hv_range_c:   cover property (range_eff[HV_CH] == RNG_MAX_HV);
    rail_range_c: cover property (range_eff[NUM_DUAL] == RNG_MAX_RAIL);
    win_fault_c:  cover property ((fault_type[NUM_DUAL] == FT_WIN) && $rose(fault[NUM_DUAL]));
    digital_c:    cover property ($rose(digital_mode[0]) ##1 !fault[0]);
endmodule : supply_fault_detector

// *** include/supply_fault_pkg.sv ***
package supply_fault_pkg;
    localparam int NUM_CH   = 10;
    localparam int NUM_DUAL = 5;
    localparam int HV_CH    = 9;
    localparam int THR_W    = 8;
    localparam int CNT_W    = 12;
    localparam int CLK_MHZ  = 25;

    // glitch filter periods in microseconds and their cycle counts
    localparam int FILT_0_US   = 0;
    localparam int FILT_5_US   = 5;
    localparam int FILT_10_US  = 10;
    localparam int FILT_20_US  = 20;
    localparam int FILT_30_US  = 30;
    localparam int FILT_50_US  = 50;
    localparam int FILT_75_US  = 75;
    localparam int FILT_100_US = 100;
    localparam logic [CNT_W-1:0] FILT_0_CYC   = CNT_W'(FILT_0_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] FILT_5_CYC   = CNT_W'(FILT_5_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] FILT_10_CYC  = CNT_W'(FILT_10_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] FILT_20_CYC  = CNT_W'(FILT_20_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] FILT_30_CYC  = CNT_W'(FILT_30_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] FILT_50_CYC  = CNT_W'(FILT_50_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] FILT_75_CYC  = CNT_W'(FILT_75_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] FILT_100_CYC = CNT_W'(FILT_100_US * CLK_MHZ);

    // highest range index per input kind
    localparam logic [1:0] RNG_MAX_DUAL = 2'h0;
    localparam logic [1:0] RNG_MAX_RAIL = 2'h2;
    localparam logic [1:0] RNG_MAX_HV   = 2'h1;

    localparam logic             RST_FLAG = 1'h0;
    localparam logic [CNT_W-1:0] RST_CNT  = 12'h000;
    localparam logic [1:0]       RST_RNG  = 2'h0;
    localparam logic [THR_W-1:0] RST_CODE = 8'h00;

    typedef enum logic [1:0] {
        FT_OFF = 2'b00,
        FT_UV  = 2'b01,
        FT_OV  = 2'b10,
        FT_WIN = 2'b11
    } fault_type_t;

    typedef struct packed {
        logic             uv;
        logic             ov;
        logic             flt;
        logic [CNT_W-1:0] cnt;
    } chan_state_t;

    function automatic logic [CNT_W-1:0] filt_cycles(input logic [2:0] sel);
        case (sel)
            3'h0:    filt_cycles = FILT_0_CYC;
            3'h1:    filt_cycles = FILT_5_CYC;
            3'h2:    filt_cycles = FILT_10_CYC;
            3'h3:    filt_cycles = FILT_20_CYC;
            3'h4:    filt_cycles = FILT_30_CYC;
            3'h5:    filt_cycles = FILT_50_CYC;
            3'h6:    filt_cycles = FILT_75_CYC;
            default: filt_cycles = FILT_100_CYC;
        endcase
    endfunction : filt_cycles

    function automatic logic [1:0] range_max(input int ch);
        if (ch < NUM_DUAL) begin
            range_max = RNG_MAX_DUAL;
        end else if (ch == HV_CH) begin
            range_max = RNG_MAX_HV;
        end else begin
            range_max = RNG_MAX_RAIL;
        end
    endfunction : range_max
endpackage : supply_fault_pkg

// *** design/fault_channel.sv ***
module fault_channel
    import supply_fault_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [THR_W-1:0] code,
    input  wire fault_type_t      ftype,
    input  wire logic [THR_W-1:0] uv_thr,
    input  wire logic [THR_W-1:0] ov_thr,
    input  wire logic [THR_W-1:0] hyst,
    input  wire logic [2:0]       filt_sel,
    output logic                  fault
);
    chan_state_t      st_r;
    chan_state_t      st_nxt;
    logic [THR_W:0]   uv_rel;
    logic [THR_W-1:0] ov_rel;
    logic [CNT_W-1:0] lim;
    logic             has_uv;
    logic             has_ov;
    logic             raw;

    // widen the under release and floor the over release at zero so a large hysteresis never wraps the release point
    assign uv_rel = {1'h0, uv_thr} + {1'h0, hyst};
    assign ov_rel = (ov_thr > hyst) ? ov_thr - hyst : RST_CODE;
    assign lim    = filt_cycles(filt_sel);
    assign has_uv = (ftype == FT_UV) || (ftype == FT_WIN);
    assign has_ov = (ftype == FT_OV) || (ftype == FT_WIN);
    assign raw    = st_r.uv | st_r.ov;  // see (R04)

    always_comb begin
        st_nxt = st_r;
        if (st_r.uv) begin
            st_nxt.uv = has_uv && !({1'h0, code} > uv_rel);  // see (R06)
        end else begin
            st_nxt.uv = has_uv && (code < uv_thr);  // see (R02)
        end
        if (st_r.ov) begin
            st_nxt.ov = has_ov && !(code < ov_rel);  // see (R05)
        end else begin
            st_nxt.ov = has_ov && (code > ov_thr);  // see (R03)
        end
        if (ftype == FT_OFF) begin
            st_nxt.flt = RST_FLAG;  // see (R14)
            st_nxt.cnt = RST_CNT;
        end else if (raw == st_r.flt) begin
            st_nxt.cnt = RST_CNT;  // see (R07)
        end else if (st_r.cnt >= lim) begin
            st_nxt.flt = raw;  // see (R13)
            st_nxt.cnt = RST_CNT;
        end else begin
            st_nxt.cnt = st_r.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{uv: RST_FLAG, ov: RST_FLAG, flt: RST_FLAG, cnt: RST_CNT};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fault = st_r.flt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    uv_detect_a: assert property ( // see (R02)
        has_uv && (code < uv_thr) |=> st_r.uv)
        else $error("under-voltage not detected");
    ov_detect_a: assert property ( // see (R03)
        has_ov && (code > ov_thr) |=> st_r.ov)
        else $error("over-voltage not detected");
    window_or_a: assert property ( // see (R04)
        (ftype == FT_WIN) && (lim == RST_CNT) && (st_r.uv || st_r.ov) ##1
        (ftype == FT_WIN) |-> st_r.flt)
        else $error("window fault missing");
    ov_hyst_a: assert property ( // see (R05)
        st_r.ov && has_ov && (code >= ov_rel) |=> st_r.ov)
        else $error("over-voltage released inside hysteresis");
    uv_hyst_a: assert property ( // see (R06)
        st_r.uv && has_uv && ({1'h0, code} <= uv_rel) |=> st_r.uv)
        else $error("under-voltage released inside hysteresis");
    filt_hold_a: assert property ( // see (R13)
        (ftype != FT_OFF) && (raw != st_r.flt) && (st_r.cnt < lim)
        |=> $stable(st_r.flt))
        else $error("glitch filter passed a short pulse");
    off_clear_a: assert property ( // see (R14)
        (ftype == FT_OFF) |=> !st_r.flt)
        else $error("disabled channel shows fault");

    uv_seen_c:   cover property (st_r.uv && st_r.flt && ftype == FT_UV);
    ov_seen_c:   cover property (st_r.ov && st_r.flt && ftype == FT_OV);
    filt_full_c: cover property ((lim == FILT_100_CYC) && $rose(st_r.flt));
endmodule : fault_channel

// *** verification/rail_source.sv ***
module rail_source
    import supply_fault_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic [NUM_CH-1:0][THR_W-1:0] level_req,
    output logic      [NUM_CH-1:0][THR_W-1:0] rail_code
);
    timeunit 1ns;
    timeprecision 1ns;

    // codes move only on edges, so the sync stage never sees a torn code
    always_ff @(posedge clk) begin
        rail_code <= level_req;
    end
endmodule : rail_source

// *** verification/supply_fault_detector_bench.sv ***
module supply_fault_detector_bench
    import supply_fault_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                         clk          = 1'h0;
    logic                         nrst         = 1'h0;
    logic [NUM_CH-1:0][THR_W-1:0] level        = {NUM_CH{8'h80}};
    logic [NUM_CH-1:0][THR_W-1:0] rail_code;
    fault_type_t [NUM_CH-1:0]     fault_type   = '0;
    // thresholds kept in range with under below over
    logic [NUM_CH-1:0][THR_W-1:0] uv_thr       = {NUM_CH{8'h40}};
    logic [NUM_CH-1:0][THR_W-1:0] ov_thr       = {NUM_CH{8'hc0}};
    logic [NUM_CH-1:0][THR_W-1:0] hyst         = {NUM_CH{8'h10}};
    logic [NUM_CH-1:0][2:0]       filt_sel     = '0;
    logic [NUM_CH-1:0][1:0]       range_sel    = '0;
    logic [NUM_DUAL-1:0]          digital_mode = '0;
    logic [NUM_CH-1:0]            fault;
    logic [NUM_CH-1:0][1:0]       range_eff;
    int                           errors       = 0;
    int                           total_checks = 0;
    int                           cycles       = 0;
    int                           filt_us [8]  = '{0, 5, 10, 20, 30, 50, 75, 100};

    always #20 clk = ~clk;

    rail_source u_rails (.clk(clk), .level_req(level), .rail_code(rail_code));

    supply_fault_detector u_dut (
        .clk(clk), .nrst(nrst), .rail_code(rail_code), .fault_type(fault_type),
        .uv_thr(uv_thr), .ov_thr(ov_thr), .hyst(hyst), .filt_sel(filt_sel),
        .range_sel(range_sel), .digital_mode(digital_mode), .fault(fault),
        .range_eff(range_eff)
    );

    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic set_type(input fault_type_t ft, input logic [NUM_CH-1:0] mask);
        @(posedge clk);
        for (int i = 0; i < NUM_CH; i++) begin
            fault_type[i] <= mask[i] ? ft : FT_OFF;
        end
    endtask : set_type

    // drive all rails, wait n further edges, compare fault vector
    task automatic step(input logic [7:0] lvl, input int n, input logic [NUM_CH-1:0] exp);
        @(posedge clk);
        level <= {NUM_CH{lvl}};
        repeat (n) @(posedge clk);
        @(negedge clk);
        check("fault", 32'(exp), 32'(fault));
    endtask : step

    always @(posedge clk) begin
        cycles++;
        // longest filter pass needs about 9000 edges; total near 26000
        if (cycles == 40000) begin
            errors++;
            $display("[ERR] run_length expected below 40000 seen %0d", cycles);
            summarize();
        end
    end

    initial begin
        logic [1:0] rexp;
        int         lim;
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            range_sel <= {NUM_CH{2'(r)}};
            repeat (2) @(posedge clk);
            @(negedge clk);
            for (int ch = 0; ch < NUM_CH; ch++) begin
                rexp = (ch < NUM_DUAL) ? 2'h0 : ((ch == HV_CH) ? 2'h1 : 2'h2);
                if (r < int'(rexp)) begin
                    rexp = 2'(r);
                end
                check("range_eff", 32'(rexp), 32'(range_eff[ch]));
            end
        end
        set_type(FT_UV, 10'h2aa);
        step(8'h3f, 6, 10'h2aa);
        set_type(FT_UV, 10'h3ff);
        step(8'h40, 6, 10'h3ff);
        step(8'h50, 6, 10'h3ff);
        step(8'h51, 6, 10'h000);
        step(8'h40, 6, 10'h000);
        @(posedge clk);
        digital_mode <= 5'h1f;
        step(8'h3f, 6, 10'h3e0);
        @(posedge clk);
        digital_mode <= 5'h00;
        step(8'h80, 6, 10'h000);
        set_type(FT_OV, 10'h3ff);
        step(8'hc0, 6, 10'h000);
        step(8'hc1, 6, 10'h3ff);
        step(8'hb0, 6, 10'h3ff);
        step(8'haf, 6, 10'h000);
        set_type(FT_WIN, 10'h3ff);
        step(8'h3f, 6, 10'h3ff);
        step(8'h80, 6, 10'h000);
        step(8'hc1, 6, 10'h3ff);
        set_type(FT_OFF, 10'h3ff);
        step(8'hc1, 3, 10'h000);
        set_type(FT_UV, 10'h3ff);
        step(8'h80, 6, 10'h000);
        for (int s = 0; s < 8; s++) begin
            lim = filt_us[s] * CLK_MHZ;
            @(posedge clk);
            filt_sel <= {NUM_CH{3'(s)}};
            // a glitch of half the period must be swallowed
            if (lim > 0) begin
                @(posedge clk);
                level <= {NUM_CH{8'h3f}};
                repeat (lim / 2) @(posedge clk);
                level <= {NUM_CH{8'h80}};
                repeat (lim + 8) @(posedge clk);
                @(negedge clk);
                check("fault", 32'h0, 32'(fault));
            end
            step(8'h3f, lim + 3, 10'h000);
            step(8'h3f, 1, 10'h3ff);
            step(8'h80, lim + 3, 10'h3ff);
            step(8'h80, 1, 10'h000);
        end
        summarize();
    end
endmodule : supply_fault_detector_bench
